// ===== rtl/sac_ctrl.sv
/*
  control logic of the serial converter: select recognition, address capture,
  result shift-out, sample extension, conversion timing and done flag.
  assumes an analog core that samples chan_sel while sample_en is high, converts
  while convert_en is high and presents conv_code at the end of conversion.
*/
`timescale 1ns/10ps
module sac_ctrl #(
  parameter int CONV_CYCLES = sac_pkg::CONV_CYC,
  parameter int DIV_CYCLES  = sac_pkg::DIV_CYC
) (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       io_clk,
  input  wire logic       cs_n,
  input  wire logic       addr_in,
  input  wire logic [7:0] conv_code,
  output logic            dout,
  output logic            dout_oe_n,
  output logic            eoc,
  output logic            sample_en,
  output logic            convert_en,
  output logic [3:0]      chan_sel
);

  localparam int TMR_W = $clog2(CONV_CYCLES + sac_pkg::EXT_SAMPLE_PER + 1);
  localparam int DIV_W = $clog2(DIV_CYCLES + 1);

  // refused at elaboration: counts below two; a divider of one makes the tick rise and fall coincide
  if (CONV_CYCLES < 2) begin : g_bad_conv
    $error("sac_ctrl: conversion count too small");
  end
  if (DIV_CYCLES < 2) begin : g_bad_div
    $error("sac_ctrl: divider count too small");
  end

  // link domain: record shift clock edges as toggles, hold address bit

  logic rise_tgl_ff;
  logic nxt_rise_tgl;
  logic addr_bit_ff;
  logic nxt_addr_bit;
  logic fall_tgl_ff;
  logic nxt_fall_tgl;

  always_comb begin
    nxt_rise_tgl = ~rise_tgl_ff;
    nxt_addr_bit = addr_in;
    nxt_fall_tgl = ~fall_tgl_ff;
  end

  // address sampled on the shift clock rising edge
  always_ff @(posedge io_clk or posedge rst) begin
    if (rst) begin
      rise_tgl_ff <= 1'b0;
      addr_bit_ff <= 1'b0;
    end else begin
      rise_tgl_ff <= nxt_rise_tgl;
      addr_bit_ff <= nxt_addr_bit;
    end
  end

  always_ff @(negedge io_clk or posedge rst) begin
    if (rst) begin
      fall_tgl_ff <= 1'b0;
    end else begin
      fall_tgl_ff <= nxt_fall_tgl;
    end
  end

  // crossing into the system domain

  sac_pkg::sac_link_t lnk_raw;
  sac_pkg::sac_link_t lnk_s;
  logic               cs_n_s;

  assign lnk_raw = '{rise_tgl: rise_tgl_ff, fall_tgl: fall_tgl_ff, addr_bit: addr_bit_ff};

  sac_sync #(
    .W       ($bits(sac_pkg::sac_link_t)),
    .RST_VAL (sac_pkg::LINK_RST)
  ) u_link_sync (
    .clk (sys_clk),
    .rst (rst),
    .d   (lnk_raw),
    .q   (lnk_s)
  );

  sac_sync #(
    .W       (1),
    .RST_VAL (1'b1)
  ) u_cs_sync (
    .clk (sys_clk),
    .rst (rst),
    .d   (cs_n),
    .q   (cs_n_s)
  );

  // system domain state

  sac_pkg::sac_state_t state_ff;
  sac_pkg::sac_state_t nxt_state;
  logic [DIV_W-1:0]    div_ff;
  logic [DIV_W-1:0]    nxt_div;
  logic [1:0]          wait_cnt_ff;
  logic [1:0]          nxt_wait_cnt;
  logic [2:0]          rise_cnt_ff;
  logic [2:0]          nxt_rise_cnt;
  logic [3:0]          fall_cnt_ff;
  logic [3:0]          nxt_fall_cnt;
  logic [3:0]          addr_sh_ff;
  logic [3:0]          nxt_addr_sh;
  logic [3:0]          chan_ff;
  logic [3:0]          nxt_chan;
  logic [7:0]          result_ff;
  logic [7:0]          nxt_result;
  logic [TMR_W-1:0]    tmr_ff;
  logic [TMR_W-1:0]    nxt_tmr;
  logic                dout_ff;
  logic                nxt_dout;
  logic                oe_n_ff;
  logic                nxt_oe_n;
  logic                eoc_ff;
  logic                nxt_eoc;
  logic                sample_ff;
  logic                nxt_sample;
  logic                convert_ff;
  logic                nxt_convert;
  logic                last_rise_ff;
  logic                nxt_last_rise;
  logic                last_fall_ff;
  logic                nxt_last_fall;
  logic                rise_pend_ff;
  logic                nxt_rise_pend;
  logic                cs_low_prev_ff;
  logic                nxt_cs_low_prev;

  logic                tick_rise;
  logic                tick_fall;
  logic                rise_evt;
  logic                fall_evt;
  logic                cs_low;
  logic                cs_fall;
  logic [3:0]          fall_next;
  logic [7:0]          new_result;

  always_comb begin
    nxt_state       = state_ff;
    nxt_wait_cnt    = wait_cnt_ff;
    nxt_rise_cnt    = rise_cnt_ff;
    nxt_fall_cnt    = fall_cnt_ff;
    nxt_addr_sh     = addr_sh_ff;
    nxt_chan        = chan_ff;
    nxt_result      = result_ff;
    nxt_tmr         = tmr_ff;
    nxt_dout        = dout_ff;
    nxt_oe_n        = oe_n_ff;
    nxt_eoc         = eoc_ff;
    nxt_sample      = sample_ff;
    nxt_convert     = convert_ff;

    // internal system clock, roughly one megahertz
    if (div_ff == DIV_W'(DIV_CYCLES - 1)) begin
      nxt_div = '0;
    end else begin
      nxt_div = div_ff + DIV_W'(1);
    end
    tick_rise = (div_ff == '0);
    tick_fall = (div_ff == DIV_W'(DIV_CYCLES / 2));

    // rise acted on one cycle late so the synced address bit has settled
    nxt_last_rise   = lnk_s.rise_tgl;
    nxt_rise_pend   = (lnk_s.rise_tgl != last_rise_ff);
    rise_evt        = rise_pend_ff;
    nxt_last_fall   = lnk_s.fall_tgl;
    fall_evt        = (lnk_s.fall_tgl != last_fall_ff);
    cs_low          = ~cs_n_s;
    nxt_cs_low_prev = cs_low;
    cs_fall         = cs_low & ~cs_low_prev_ff;
    fall_next       = fall_cnt_ff + 4'h1;

    // self-test input replaces the analog code
    if (chan_ff == sac_pkg::SELFTEST_CHAN) begin
      new_result = sac_pkg::SELFTEST_CODE;
    end else begin
      new_result = conv_code;
    end

    case (state_ff)
      sac_pkg::ST_IDLE: begin
        nxt_oe_n = 1'b1;
        if (cs_low) begin
          nxt_state    = sac_pkg::ST_WAIT;
          nxt_wait_cnt = 2'h0;
        end
      end

      sac_pkg::ST_WAIT: begin
        if (!cs_low) begin
          nxt_state = sac_pkg::ST_IDLE;
        end else if (tick_rise && wait_cnt_ff < 2'(sac_pkg::WAIT_RISES)) begin
          nxt_wait_cnt = wait_cnt_ff + 2'h1;
        end else if (tick_fall && wait_cnt_ff == 2'(sac_pkg::WAIT_RISES)) begin
          nxt_state    = sac_pkg::ST_SHIFT;
          nxt_dout     = result_ff[7];
          nxt_oe_n     = 1'b0;
          nxt_rise_cnt = 3'h0;
          nxt_fall_cnt = 4'h0;
        end
      end

      sac_pkg::ST_SHIFT: begin
        if (!cs_low) begin
          // transfer abandoned; output floats at once
          nxt_state = sac_pkg::ST_IDLE;
          nxt_oe_n  = 1'b1;
        end else begin
          if (rise_evt && rise_cnt_ff < 3'(sac_pkg::ADDR_CLKS)) begin
            nxt_addr_sh  = {addr_sh_ff[2:0], lnk_s.addr_bit};
            nxt_rise_cnt = rise_cnt_ff + 3'h1;
          end
          if (fall_evt) begin
            nxt_fall_cnt = fall_next;
            if (fall_next == 4'(sac_pkg::ADDR_CLKS)) begin
              nxt_chan   = addr_sh_ff;
              nxt_sample = 1'b1;
            end
            if (fall_next < 4'(sac_pkg::FRAME_CLKS)) begin
              // falls one-four give bits 2-5, five-seven give bits 6-8
              nxt_dout = result_ff[3'(7 - fall_next)];
            end else begin
              nxt_oe_n  = 1'b1;
              nxt_eoc   = 1'b0;
              nxt_state = sac_pkg::ST_HOLD;
              nxt_tmr   = '0;
            end
          end
        end
      end

      sac_pkg::ST_HOLD, sac_pkg::ST_CONV: begin
        if (cs_fall) begin
          // fresh select while busy resets the sequence
          nxt_state    = sac_pkg::ST_WAIT;
          nxt_wait_cnt = 2'h0;
          nxt_sample   = 1'b0;
          nxt_convert  = 1'b0;
        end else if (cs_low && rise_evt) begin
          // early transfer: old result shifts out, running conversion dropped
          nxt_state    = sac_pkg::ST_SHIFT;
          nxt_sample   = 1'b0;
          nxt_convert  = 1'b0;
          nxt_oe_n     = 1'b0;
          nxt_dout     = result_ff[7];
          nxt_addr_sh  = {addr_sh_ff[2:0], lnk_s.addr_bit};
          nxt_rise_cnt = 3'h1;
          nxt_fall_cnt = 4'h0;
        end else if (state_ff == sac_pkg::ST_HOLD) begin
          if (tick_rise) begin
            nxt_tmr = tmr_ff + TMR_W'(1);
            if (tmr_ff == TMR_W'(sac_pkg::EXT_SAMPLE_PER - 1)) begin
              nxt_sample  = 1'b0;
              nxt_convert = 1'b1;
              nxt_state   = sac_pkg::ST_CONV;
              nxt_tmr     = '0;
            end
          end
        end else begin
          // fixed conversion time keeps a full cycle inside forty microseconds
          nxt_tmr = tmr_ff + TMR_W'(1);
          if (tmr_ff == TMR_W'(CONV_CYCLES - 1)) begin
            nxt_result  = new_result;
            nxt_convert = 1'b0;
            nxt_eoc     = 1'b1;
            if (cs_low) begin
              // select still low: next transfer may follow directly
              nxt_state    = sac_pkg::ST_SHIFT;
              nxt_dout     = new_result[7];
              nxt_oe_n     = 1'b0;
              nxt_rise_cnt = 3'h0;
              nxt_fall_cnt = 4'h0;
            end else begin
              nxt_state = sac_pkg::ST_IDLE;
            end
          end
        end
      end

      default: begin
        nxt_state = sac_pkg::ST_IDLE;
        nxt_oe_n  = 1'b1;
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_ff       <= sac_pkg::ST_IDLE;
      div_ff         <= '0;
      wait_cnt_ff    <= 2'h0;
      rise_cnt_ff    <= 3'h0;
      fall_cnt_ff    <= 4'h0;
      addr_sh_ff     <= 4'h0;
      chan_ff        <= sac_pkg::CHAN_RST;
      result_ff      <= sac_pkg::RESULT_RST;
      tmr_ff         <= '0;
      dout_ff        <= 1'b0;
      oe_n_ff        <= 1'b1;
      eoc_ff         <= 1'b1;
      sample_ff      <= 1'b0;
      convert_ff     <= 1'b0;
      last_rise_ff   <= 1'b0;
      last_fall_ff   <= 1'b0;
      rise_pend_ff   <= 1'b0;
      cs_low_prev_ff <= 1'b0;
    end else begin
      state_ff       <= nxt_state;
      div_ff         <= nxt_div;
      wait_cnt_ff    <= nxt_wait_cnt;
      rise_cnt_ff    <= nxt_rise_cnt;
      fall_cnt_ff    <= nxt_fall_cnt;
      addr_sh_ff     <= nxt_addr_sh;
      chan_ff        <= nxt_chan;
      result_ff      <= nxt_result;
      tmr_ff         <= nxt_tmr;
      dout_ff        <= nxt_dout;
      oe_n_ff        <= nxt_oe_n;
      eoc_ff         <= nxt_eoc;
      sample_ff      <= nxt_sample;
      convert_ff     <= nxt_convert;
      last_rise_ff   <= nxt_last_rise;
      last_fall_ff   <= nxt_last_fall;
      rise_pend_ff   <= nxt_rise_pend;
      cs_low_prev_ff <= nxt_cs_low_prev;
    end
  end

  assign dout       = dout_ff;
  assign dout_oe_n  = oe_n_ff;
  assign eoc        = eoc_ff;
  assign sample_en  = sample_ff;
  assign convert_en = convert_ff;
  assign chan_sel   = chan_ff;

endmodule : sac_ctrl

// ===== rtl/sac_pkg.sv
/*
  constants, state and carrier types for the serial converter access control.
  assumes a 100 mhz system clock and a host-driven shift clock on its own domain.
*/
// Contract
// - select high: output floats, clock and address ignored
// - select recognized after two rises, one fall
// - recognized select drives previous result msb
// - first four rises capture address msb first
// - first four falls shift result bits two-five
// - sampling starts after fourth falling edge
// - next three falls shift bits six-eight
// - eighth fall floats output, twelve-period sample extension
// - conversion follows, about twenty microseconds
// - select may stay low across transfers
// - select fall during conversion aborts it
// - new transfer during conversion aborts, restarts
// - done flag falls on eighth falling edge
// - done flag rises when conversion completes
// - full cycle repeatable every forty microseconds
// - address selects eleven inputs or self-test
// - code 1011 self-test converts near mid-scale
package sac_pkg;

  localparam int CLK_NS          = 10;
  localparam int SYS_PERIOD_NS   = 1000;
  localparam int DIV_CYC         = SYS_PERIOD_NS / CLK_NS;
  localparam int DIV_HALF        = DIV_CYC / 2;
  localparam int WAIT_RISES      = 2;
  localparam int ADDR_BITS       = 4;
  localparam int RES_BITS        = 8;
  localparam int ADDR_CLKS       = 4;
  localparam int FRAME_CLKS      = 8;
  localparam int EXT_SAMPLE_PER  = 12;
  localparam int CONV_NS         = 20000;
  localparam int CONV_CYC        = CONV_NS / CLK_NS;
  localparam int CYCLE_NS        = 40000;
  localparam int NUM_INPUTS      = 11;

  localparam logic [3:0] SELFTEST_CHAN = 4'hb;
  localparam logic [7:0] SELFTEST_CODE = 8'h80;
  localparam logic [7:0] RESULT_RST    = 8'h00;
  localparam logic [3:0] CHAN_RST      = 4'h0;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_WAIT,
    ST_SHIFT,
    ST_HOLD,
    ST_CONV
  } sac_state_t;

  typedef struct packed {
    logic rise_tgl;
    logic fall_tgl;
    logic addr_bit;
  } sac_link_t;

  localparam sac_link_t LINK_RST = '{rise_tgl: 1'b0, fall_tgl: 1'b0, addr_bit: 1'b0};

endpackage : sac_pkg

// ===== rtl/sac_sync.sv
/*
  two flip-flop level synchronizer, parameterised width and reset value.
  assumes each bit is a level or toggle held for several destination clocks.
*/
`timescale 1ns/10ps
module sac_sync #(
  parameter int         W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  // refused at elaboration: a zero-width crossing has nothing to carry
  if (W < 1) begin : g_bad_width
    $error("sac_sync: width must be at least one");
  end

  // first stage feeds only the second
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_ff <= RST_VAL;
      sync_ff <= RST_VAL;
    end else begin
      meta_ff <= d;
      sync_ff <= meta_ff;
    end
  end

  assign q = sync_ff;

endmodule : sac_sync

// ===== verification/sac_ctrl_props.sv
/*
  port assertions for sac_ctrl, bound into every instance.
  assumes the sys_clk domain and the parameters of the bound instance.
*/
`timescale 1ns/10ps
module sac_ctrl_props #(
  parameter int CONV_CYCLES = sac_pkg::CONV_CYC,
  parameter int DIV_CYCLES  = sac_pkg::DIV_CYC
) (
  input wire logic       sys_clk,
  input wire logic       rst,
  input wire logic       io_clk,
  input wire logic       cs_n,
  input wire logic       addr_in,
  input wire logic [7:0] conv_code,
  input wire logic       dout,
  input wire logic       dout_oe_n,
  input wire logic       eoc,
  input wire logic       sample_en,
  input wire logic       convert_en,
  input wire logic [3:0] chan_sel
);
  int   conv_cnt_ff;
  int   nxt_conv_cnt;
  int   ext_cnt_ff;
  int   nxt_ext_cnt;
  logic code_msb;
  assign code_msb = conv_code[7];
  // extension only counted while the output floats, so an aborting frame restarts it
  always_comb begin
    nxt_conv_cnt = convert_en ? conv_cnt_ff + 1 : 0;
    nxt_ext_cnt  = (!eoc && sample_en && dout_oe_n) ? ext_cnt_ff + 1 : 0;
  end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      conv_cnt_ff <= 0;
      ext_cnt_ff  <= 0;
    end else begin
      conv_cnt_ff <= nxt_conv_cnt;
      ext_cnt_ff  <= nxt_ext_cnt;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence s_float_sample;
    (dout_oe_n && sample_en && !convert_en)[*4];
  endsequence
  a_float_when_idle: assert property (cs_n[*4] |-> dout_oe_n)
    else $error("output driven while deselected");
  a_select_wait: assert property ($fell(cs_n) && dout_oe_n |=> dout_oe_n[*5])
    else $error("select acted on too early");
  a_eighth_floats: assert property ($fell(eoc) |-> $rose(dout_oe_n) ##1 s_float_sample)
    else $error("eighth edge did not float output");
  a_extend_len: assert property ($rose(convert_en) |->
      ext_cnt_ff >= 11 * DIV_CYCLES && ext_cnt_ff <= 13 * DIV_CYCLES)
    else $error("sample extension length wrong");
  a_conv_len: assert property ($rose(eoc) |->
      $fell(convert_en) && conv_cnt_ff >= CONV_CYCLES - 1 && conv_cnt_ff <= CONV_CYCLES + 1)
    else $error("conversion length wrong");
  a_new_msb: assert property ($rose(eoc) && !cs_n && !$past(cs_n, 4) |-> !dout_oe_n &&
      dout == ((chan_sel == sac_pkg::SELFTEST_CHAN) ? sac_pkg::SELFTEST_CODE[7] : $past(code_msb)))
    else $error("new result msb not driven");
  a_sample_in_frame: assert property ($rose(sample_en) |-> !dout_oe_n ##1 $stable(chan_sel)[*4])
    else $error("sampling started outside frame");
  a_abort_select: assert property ($fell(cs_n) && convert_en |-> ##[1:4] !(convert_en || sample_en))
    else $error("select fall did not abort");
  a_phase_mutex: assert property (!(sample_en && convert_en))
    else $error("sampling and converting together");
endmodule : sac_ctrl_props

bind sac_ctrl sac_ctrl_props #(.CONV_CYCLES(CONV_CYCLES), .DIV_CYCLES(DIV_CYCLES)) sac_ctrl_props_i (.*);

// ===== verification/sac_host.sv
/*
  host model: drives select, shift clock and address, reads the result.
  assumes a 100 mhz sys_clk for the recognition wait.
*/
`timescale 1ns/10ps
module sac_host (
  input  wire logic sys_clk,
  input  wire logic dout,
  input  wire logic dout_oe_n,
  output logic      cs_n,
  output logic      io_clk,
  output logic      addr_in
);
  logic [7:0] rx;
  event       got;
  initial begin
    cs_n    = 1'b1;
    io_clk  = 1'b0;
    addr_in = 1'b0;
  end
  task automatic frame(input logic [3:0] addr, input logic rel);
    int i;
    if (cs_n) begin
      @(posedge sys_clk);
      #1 cs_n = 1'b0;
      repeat (30) @(posedge sys_clk);
    end
    // odd offset keeps the shift clock unrelated to sys_clk
    #13.7;
    for (i = 0; i < 8; i++) begin
      addr_in = (i < 4) ? addr[3-i] : ~addr_in;
      #20 io_clk = 1'b1;
      #40 rx[7-i] = dout_oe_n ? 1'bx : dout;
      io_clk = 1'b0;
      #20;
    end
    #20 if (rel) cs_n = 1'b1;
    -> got;
  endtask : frame
  // shift clock and address toggling with select high
  task automatic noise();
    int i;
    for (i = 0; i < 6; i++) begin
      #40 io_clk = ~io_clk;
      addr_in = ~addr_in;
    end
  endtask : noise
endmodule : sac_host

// ===== verification/tb_serial_adc_access_control.sv
/*
  self-checking bench for sac_ctrl with a host model on the link.
  assumes shortened conversion and internal clock counts.
*/
`timescale 1ns/10ps
module tb_serial_adc_access_control;
  localparam int CONV = 20;
  localparam int DIV  = 4;
  logic        sys_clk;
  logic        rst;
  logic [7:0]  conv_code;
  logic        io_clk;
  logic        cs_n;
  logic        addr_in;
  logic        dout;
  logic        dout_oe_n;
  logic        eoc;
  logic        sample_en;
  logic        convert_en;
  logic [3:0]  chan_sel;
  logic [7:0]  exp_q[$];
  logic [7:0]  last;
  logic [7:0]  keep;
  logic [31:0] seed;
  int          error_cnt;
  int          samples_checked;
  int          i;
  int          n;

  sac_ctrl #(.CONV_CYCLES(CONV), .DIV_CYCLES(DIV)) sac_ctrl_i (
    .sys_clk(sys_clk), .rst(rst), .io_clk(io_clk), .cs_n(cs_n), .addr_in(addr_in),
    .conv_code(conv_code), .dout(dout), .dout_oe_n(dout_oe_n), .eoc(eoc),
    .sample_en(sample_en), .convert_en(convert_en), .chan_sel(chan_sel));
  sac_host sac_host_i (
    .sys_clk(sys_clk), .dout(dout), .dout_oe_n(dout_oe_n), .cs_n(cs_n),
    .io_clk(io_clk), .addr_in(addr_in));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs

  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    samples_checked++;
    if (seen !== want) begin
      error_cnt++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, want);
    end
  endtask : check

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : give_verdict

  // the expected read is whatever the device holds before this frame
  task automatic xfer(input logic [3:0] ch, input logic rel);
    logic [7:0] code;
    seed = xs(seed);
    code = seed[7:0];
    @(posedge sys_clk);
    #1 conv_code = code;
    exp_q.push_back(last);
    sac_host_i.frame(ch, rel);
    check({4'h0, chan_sel}, {4'h0, ch});
    check({7'h00, eoc}, 8'h00);
    last = (ch == sac_pkg::SELFTEST_CHAN) ? sac_pkg::SELFTEST_CODE : code;
  endtask : xfer

  task automatic wait_eoc();
    // look one step after the edge so the flag has settled
    for (n = 0; n < 400 && eoc !== 1'b1; n++)
      @(posedge sys_clk) #1;
    check({7'h00, eoc}, 8'h01);
  endtask : wait_eoc

  always @(sac_host_i.got) begin
    check(sac_host_i.rx, exp_q.pop_front());
  end

  initial begin
    #200000;
    error_cnt++;
    $display("unexpected at %0t: run hung", $time);
    give_verdict();
  end

  initial begin
    rst = 1'b1;
    conv_code = 8'h00;
    seed = 32'hf168;
    last = sac_pkg::RESULT_RST;
    error_cnt = 0;
    samples_checked = 0;
    repeat (6) @(posedge sys_clk);
    #1 rst = 1'b0;
    check({dout_oe_n, eoc, sample_en, convert_en, chan_sel}, 8'hc0);
    for (i = 0; i < 12; i++) begin
      xfer(i[3:0], i[0]);
      wait_eoc();
    end
    $display("test channels done");
    sac_host_i.noise();
    check({3'h0, dout_oe_n, chan_sel}, 8'h1b);
    keep = last;
    xfer(4'h3, 1'b0);
    last = keep;
    repeat (10) @(posedge sys_clk);
    xfer(4'h5, 1'b1);
    wait_eoc();
    $display("test restart abort done");
    keep = last;
    xfer(4'h7, 1'b1);
    last = keep;
    for (n = 0; n < 200 && convert_en !== 1'b1; n++)
      @(posedge sys_clk) #1;
    check({6'h00, sample_en, convert_en}, 8'h01);
    xfer(4'h9, 1'b1);
    wait_eoc();
    xfer(4'h0, 1'b1);
    wait_eoc();
    $display("test select abort done");
    give_verdict();
  end
endmodule : tb_serial_adc_access_control
